// ---- shared/cfgir_pkg.sv ----
// Purpose: shared constants and types for the config-output and interrupt-request link
// Assumes: one core clock shared by both ends
// Notes: widths follow the exported configuration fields
package cfgir_pkg;
  localparam int CFGIR_BUS_W = 8;
  localparam int CFGIR_DEV_W = 5;
  localparam int CFGIR_FUNC_W = 3;
  localparam int CFGIR_CMD_W = 6;
  localparam int CFGIR_DEVCTL_W = 15;
  localparam int CFGIR_LNKCTL_W = 8;
  localparam int CFGIR_MSI_W = 8;
  localparam int CFGIR_CMD_INTDIS_BIT = 5;
  localparam int CFGIR_CMD_SERR_BIT = 4;
  localparam int CFGIR_CMD_PERR_BIT = 3;
  localparam int CFGIR_CMD_BME_BIT = 2;
  localparam int CFGIR_CMD_MEM_BIT = 1;
  localparam int CFGIR_CMD_IO_BIT = 0;
  // Least edge spacing of the legacy request, in core cycles
  localparam int CFGIR_INTX_GAP_WIDE = 2;
  localparam int CFGIR_INTX_GAP_X1 = 8;
  // Host register map (word addresses)
  localparam logic [3:0] CFGIR_A_CTRL = 4'h0;
  localparam logic [3:0] CFGIR_A_STAT = 4'h1;
  localparam logic [3:0] CFGIR_A_MASK = 4'h2;
  localparam logic [3:0] CFGIR_A_MSI = 4'h3;
  localparam logic [3:0] CFGIR_A_ID = 4'h4;
  localparam logic [3:0] CFGIR_A_CMD = 4'h5;
  localparam logic [3:0] CFGIR_A_DEVCTL = 4'h6;
  localparam logic [3:0] CFGIR_A_LNKCTL = 4'h7;
  localparam int CFGIR_ST_DONE = 0;
  localparam int CFGIR_ST_REFUSE = 1;
  localparam int CFGIR_ST_CMDCHG = 2;
  localparam int CFGIR_ST_W = 3;
  typedef enum logic [1:0] {CFGIR_MSG_ASSERT, CFGIR_MSG_DEASSERT, CFGIR_MSG_MSI} cfgir_msg_t;
endpackage : cfgir_pkg

// ---- shared/cfgir_if.sv ----
// Purpose: joins the endpoint end and the user-logic end
// Assumes: both ends on core_clk
// Notes: all signals are levels sampled on core_clk
`timescale 1ns/1ps
interface cfgir_if;
  import cfgir_pkg::*;
  logic [CFGIR_BUS_W-1:0] bus_num;
  logic [CFGIR_DEV_W-1:0] dev_num;
  logic [CFGIR_FUNC_W-1:0] func_num;
  logic [CFGIR_CMD_W-1:0] cmd_bits;
  logic [CFGIR_DEVCTL_W-1:0] dev_ctl;
  logic [CFGIR_LNKCTL_W-1:0] lnk_ctl;
  logic msi_on;
  logic intx_req_n;
  logic [CFGIR_MSI_W-1:0] msi_req;
  modport dev (output bus_num, dev_num, func_num, cmd_bits, dev_ctl, lnk_ctl, msi_on,
    input intx_req_n, msi_req);
  modport usr (input bus_num, dev_num, func_num, cmd_bits, dev_ctl, lnk_ctl, msi_on,
    output intx_req_n, msi_req);
endinterface : cfgir_if

// ---- hw/cfgir_dev.sv ----
// Purpose: endpoint end: exports config state, turns request edges into messages
// Assumes: config writes arrive as one-cycle strobes from the config space logic
// Notes: messages leave as one-cycle pulses toward the transaction layer
`timescale 1ns/1ps
module cfgir_dev
  import cfgir_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  cfgir_if.dev lnk,
  input wire logic cfg_wr,
  input wire logic [CFGIR_BUS_W-1:0] cfg_wr_bus,
  input wire logic [CFGIR_DEV_W-1:0] cfg_wr_dev,
  input wire logic [CFGIR_FUNC_W-1:0] cfg_wr_func,
  input wire logic cmd_wr,
  input wire logic [CFGIR_CMD_W-1:0] cmd_wr_data,
  input wire logic devctl_wr,
  input wire logic [CFGIR_DEVCTL_W-1:0] devctl_wr_data,
  input wire logic lnkctl_wr,
  input wire logic [CFGIR_LNKCTL_W-1:0] lnkctl_wr_data,
  input wire logic msi_en_in,
  output logic msg_valid,
  output cfgir_msg_t msg_kind,
  output logic [CFGIR_MSI_W-1:0] msi_vec,
  output logic int_status
);
  logic [CFGIR_BUS_W-1:0] bus_q;
  logic [CFGIR_DEV_W-1:0] dev_q;
  logic [CFGIR_FUNC_W-1:0] func_q;
  logic [CFGIR_CMD_W-1:0] cmd_q;
  logic [CFGIR_DEVCTL_W-1:0] devctl_q;
  logic [CFGIR_LNKCTL_W-1:0] lnkctl_q;
  logic msi_on_q;
  logic intx_prev_q;
  logic [CFGIR_MSI_W-1:0] msi_prev_q;
  logic intx_fall;
  logic intx_rise;
  logic [CFGIR_MSI_W-1:0] msi_rise;

  assign lnk.bus_num = bus_q;
  assign lnk.dev_num = dev_q;
  assign lnk.func_num = func_q;
  assign lnk.cmd_bits = cmd_q;
  assign lnk.dev_ctl = devctl_q;
  assign lnk.lnk_ctl = lnkctl_q;
  assign lnk.msi_on = msi_on_q;

  // Captured identity from configuration writes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_q <= '0;
      dev_q <= '0;
      func_q <= '0;
    end else if (cfg_wr) begin
      bus_q <= cfg_wr_bus;
      dev_q <= cfg_wr_dev;
      func_q <= cfg_wr_func;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_q <= '0;
      devctl_q <= '0;
      lnkctl_q <= '0;
      msi_on_q <= 1'b0;
    end else begin
      if (cmd_wr) cmd_q <= cmd_wr_data;
      if (devctl_wr) devctl_q <= devctl_wr_data;
      if (lnkctl_wr) lnkctl_q <= lnkctl_wr_data;
      msi_on_q <= msi_en_in;
    end
  end

  // Previous-cycle copies; reset to idle so no edge fires out of reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      intx_prev_q <= 1'b1;
      msi_prev_q <= '0;
    end else begin
      intx_prev_q <= lnk.intx_req_n;
      msi_prev_q <= lnk.msi_req;
    end
  end

  assign intx_fall = intx_prev_q & ~lnk.intx_req_n & ~msi_on_q;
  assign intx_rise = ~intx_prev_q & lnk.intx_req_n & ~msi_on_q;
  assign msi_rise = (lnk.msi_req & ~msi_prev_q) & {CFGIR_MSI_W{msi_on_q}};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      int_status <= 1'b0;
    end else if (intx_fall) begin
      int_status <= 1'b1;
    end else if (intx_rise) begin
      int_status <= 1'b0;
    end
  end

  // MSI wins the message slot; legacy is off whenever MSI is on, so no clash
  always_ff @(posedge core_clk) begin
    if (srst) begin
      msg_valid <= 1'b0;
      msg_kind <= CFGIR_MSG_ASSERT;
      msi_vec <= '0;
    end else begin
      msi_vec <= msi_rise;
      if (|msi_rise) begin
        msg_valid <= 1'b1;
        msg_kind <= CFGIR_MSG_MSI;
      end else if (intx_fall && !cmd_q[CFGIR_CMD_INTDIS_BIT]) begin
        msg_valid <= 1'b1;
        msg_kind <= CFGIR_MSG_ASSERT;
      end else if (intx_rise && !cmd_q[CFGIR_CMD_INTDIS_BIT]) begin
        msg_valid <= 1'b1;
        msg_kind <= CFGIR_MSG_DEASSERT;
      end else begin
        msg_valid <= 1'b0;
      end
    end
  end
endmodule : cfgir_dev

// ---- hw/cfgir_usr.sv ----
// Purpose: user-logic end: software-driven interrupt requests over a register port
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: legacy edges are paced to the configured least spacing
`timescale 1ns/1ps
module cfgir_usr
  import cfgir_pkg::*;
#(
  parameter bit NATIVE_X1 = 1'b0
)(
  input wire logic core_clk,
  input wire logic srst,
  cfgir_if.usr lnk,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  localparam logic [3:0] GAP = NATIVE_X1 ? 4'(CFGIR_INTX_GAP_X1) : 4'(CFGIR_INTX_GAP_WIDE);
  logic want_q;
  logic req_n_q;
  logic [3:0] gap_q;
  logic [CFGIR_MSI_W-1:0] msi_q;
  logic [CFGIR_ST_W-1:0] stat_q;
  logic [CFGIR_ST_W-1:0] mask_q;
  logic intdis_q;
  logic refuse_ev;
  logic edge_ev;
  logic chg_ev;
  logic want_eff;

  // Request is forced high while disabled, so a held assert gets its deassert
  assign want_eff = want_q & ~lnk.cmd_bits[CFGIR_CMD_INTDIS_BIT];
  assign edge_ev = (want_eff == req_n_q) && (gap_q == 4'h0);
  assign refuse_ev = reg_wr && (reg_addr == CFGIR_A_CTRL) && reg_wdata[0] && lnk.msi_on;
  assign chg_ev = intdis_q != lnk.cmd_bits[CFGIR_CMD_INTDIS_BIT];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      want_q <= 1'b0;
    end else if (reg_wr && reg_addr == CFGIR_A_CTRL) begin
      want_q <= reg_wdata[0] & ~lnk.msi_on;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_n_q <= 1'b1;
      gap_q <= 4'h0;
      intdis_q <= 1'b0;
    end else begin
      intdis_q <= lnk.cmd_bits[CFGIR_CMD_INTDIS_BIT];
      if (edge_ev) begin
        req_n_q <= ~want_eff;
        gap_q <= GAP - 4'h1;
      end else if (gap_q != 4'h0) begin
        gap_q <= gap_q - 4'h1;
      end
    end
  end

  // MSI bits are levels; software writes 1 then 0 to make a rising edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      msi_q <= '0;
    end else if (reg_wr && reg_addr == CFGIR_A_MSI) begin
      msi_q <= reg_wdata[CFGIR_MSI_W-1:0];
    end
  end

  // Sticky status: set wins over a write-one clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((reg_wr && reg_addr == CFGIR_A_STAT) ?
        reg_wdata[CFGIR_ST_W-1:0] : '0)) | {chg_ev, refuse_ev, edge_ev};
      if (reg_wr && reg_addr == CFGIR_A_MASK) mask_q <= reg_wdata[CFGIR_ST_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      // A set mask bit hides its status bit from the interrupt line
      irq <= |(stat_q & ~mask_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == CFGIR_A_CTRL) begin
      reg_rdata <= {29'h0, lnk.msi_on, ~req_n_q, want_q};
    end else if (reg_addr == CFGIR_A_STAT) begin
      reg_rdata <= {29'h0, stat_q};
    end else if (reg_addr == CFGIR_A_MASK) begin
      reg_rdata <= {29'h0, mask_q};
    end else if (reg_addr == CFGIR_A_MSI) begin
      reg_rdata <= {24'h0, msi_q};
    end else if (reg_addr == CFGIR_A_ID) begin
      reg_rdata <= {16'h0, lnk.bus_num, lnk.dev_num, lnk.func_num};
    end else if (reg_addr == CFGIR_A_CMD) begin
      reg_rdata <= {26'h0, lnk.cmd_bits};
    end else if (reg_addr == CFGIR_A_DEVCTL) begin
      reg_rdata <= {17'h0, lnk.dev_ctl};
    end else if (reg_addr == CFGIR_A_LNKCTL) begin
      reg_rdata <= {24'h0, lnk.lnk_ctl};
    end else begin
      reg_rdata <= '0;
    end
  end

  assign lnk.intx_req_n = req_n_q;
  assign lnk.msi_req = msi_q;
endmodule : cfgir_usr

// ---- verification/cfgir_monitor.sv ----
// Purpose: checker for the request link and the message outputs
// Assumes: one core clock, srst synchronous
// Notes: edges are judged against the value of the cycle before
`timescale 1ns/1ps
module cfgir_monitor
  import cfgir_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [CFGIR_CMD_W-1:0] cmd_bits,
  input wire logic msi_on,
  input wire logic intx_req_n,
  input wire logic [CFGIR_MSI_W-1:0] msi_req,
  input wire logic msg_valid,
  input wire cfgir_msg_t msg_kind,
  input wire logic [CFGIR_MSI_W-1:0] msi_vec,
  input wire logic int_status
);
  logic [7:0] prev_q;
  logic [7:0] rise_q;
  logic [7:0] rise;
  // Endpoint only turns MSI request edges into messages while MSI is on
  assign rise = msi_req & ~prev_q & {8{msi_on}};
  always_ff @(posedge core_clk) begin
    prev_q <= srst ? 8'h00 : msi_req;
    rise_q <= rise;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // MSI wins a shared cycle, so legacy checks exclude it
  sequence s_fall; $fell(intx_req_n) && !msi_on && rise == 8'h00; endsequence
  sequence s_rise; $rose(intx_req_n) && !msi_on && rise == 8'h00; endsequence
  AST_INTX_ASSERT: assert property (s_fall ##0 !cmd_bits[5] |=>
    msg_valid && msg_kind == CFGIR_MSG_ASSERT) else $error("assert message missing");
  AST_INTX_DEASSERT: assert property (s_rise ##0 !cmd_bits[5] |=>
    msg_valid && msg_kind == CFGIR_MSG_DEASSERT) else $error("deassert message missing");
  AST_STAT_SET: assert property (s_fall |=> int_status)
    else $error("status not set");
  AST_STAT_CLR: assert property (s_rise |=> !int_status)
    else $error("status not cleared");
  AST_INTX_MUTE: assert property (cmd_bits[5] && rise == 8'h00 |=> !msg_valid)
    else $error("message while disabled");
  AST_MSI_SEND: assert property (rise != 8'h00 |=> msg_valid &&
    msg_kind == CFGIR_MSG_MSI && msi_vec == rise_q) else $error("msi message wrong");
  AST_MSI_IDLE: assert property (rise == 8'h00 |=> msi_vec == 8'h00)
    else $error("msi vector without edge");
  AST_MSI_MODE: assert property (msi_on |=> $stable(int_status))
    else $error("legacy edge taken in msi mode");
endmodule : cfgir_monitor

// ---- verification/cfg_outputs_and_intr_request_bench.sv ----
// Purpose: drives both ends joined by the link and checks messages and registers
// Assumes: mask bit high hides the status bit from irq
// Notes: expected results queue up and a watcher compares them
`timescale 1ns/1ps
module cfg_outputs_and_intr_request_bench;
  import cfgir_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic cfg_wr = 1'b0;
  logic [15:0] cfg_id = 16'h0000;
  logic [5:0] cmd_wr_data = 6'h00;
  logic [14:0] devctl_wr_data = 15'h0000;
  logic [7:0] lnkctl_wr_data = 8'h00;
  logic msi_en_in = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cmd_wr = 1'b0;
  logic [31:0] reg_rdata;
  logic irq, msg_valid, int_status, rd_d1;
  cfgir_msg_t msg_kind;
  logic [7:0] msi_vec, v, old;
  logic [31:0] rnd = 32'h389C;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] exp_rd[$];
  logic [9:0] exp_msg[$];
  cfgir_if lnk();
  cfgir_dev cfgir_dev_inst (.core_clk, .srst, .lnk(lnk), .cfg_wr, .cfg_wr_bus(cfg_id[15:8]),
    .cfg_wr_dev(cfg_id[7:3]), .cfg_wr_func(cfg_id[2:0]), .cmd_wr, .cmd_wr_data,
    .devctl_wr(cmd_wr), .devctl_wr_data, .lnkctl_wr(cmd_wr), .lnkctl_wr_data, .msi_en_in,
    .msg_valid, .msg_kind, .msi_vec, .int_status);
  cfgir_usr cfgir_usr_inst (.core_clk, .srst, .lnk(lnk), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq);
  cfgir_monitor cfgir_monitor_inst (.core_clk, .srst, .cmd_bits(lnk.cmd_bits),
    .msi_on(lnk.msi_on), .intx_req_n(lnk.intx_req_n), .msi_req(lnk.msi_req), .msg_valid,
    .msg_kind, .msi_vec, .int_status);
  initial forever #2 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_rd.push_back(e);
    cyc(1);
    reg_rd <= 1'b0;
    cyc(1);
  endtask : rd
  // Bounded wait for every queued result, then let irq settle
  task automatic drain();
    for (int i = 0; i < 40 && exp_msg.size() + exp_rd.size() > 0; i++) cyc(1);
    if (exp_msg.size() + exp_rd.size() > 0) begin
      err_total++;
      complete_run();
    end
    cyc(3);
  endtask : drain
  always @(posedge core_clk) begin
    rd_d1 <= reg_rd;
    if (rd_d1) chk(exp_rd.size() > 0 && reg_rdata === exp_rd.pop_front(), "read data");
    if (msg_valid === 1'b1)
      chk(exp_msg.size() > 0 && {msg_kind, msi_vec} === exp_msg.pop_front(), "message");
  end
  initial begin
    cyc(5);
    srst <= 1'b0;
    cyc(1);
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      cfg_wr <= 1'b1;
      cmd_wr <= 1'b1;
      cfg_id <= rnd[15:0];
      cmd_wr_data <= 6'h01 << i;
      devctl_wr_data <= rnd[30:16];
      lnkctl_wr_data <= rnd[31:24];
      cyc(1);
      cfg_wr <= 1'b0;
      cmd_wr <= 1'b0;
      cyc(2);
      chk({lnk.bus_num, lnk.dev_num, lnk.func_num} === cfg_id, "id");
      chk(lnk.cmd_bits === cmd_wr_data && lnk.dev_ctl === devctl_wr_data, "cmd");
      chk(lnk.lnk_ctl === lnkctl_wr_data, "link control");
      rd(CFGIR_A_ID, {16'h0, cfg_id});
      rd(CFGIR_A_DEVCTL, {17'h0, devctl_wr_data});
    end
    rd(4'hF, 32'h0);
    cmd_wr <= 1'b1;
    cmd_wr_data <= 6'h00;
    wr(CFGIR_A_STAT, 32'h7);
    cmd_wr <= 1'b0;
    exp_msg.push_back({CFGIR_MSG_ASSERT, 8'h00});
    wr(CFGIR_A_CTRL, 32'h1);
    drain();
    chk(int_status === 1'b1 && irq === 1'b1, "status set");
    rd(CFGIR_A_STAT, 32'h1);
    wr(CFGIR_A_MASK, 32'h7);
    drain();
    chk(irq === 1'b0, "masked irq");
    wr(CFGIR_A_MASK, 32'h0);
    wr(CFGIR_A_STAT, 32'h7);
    drain();
    chk(irq === 1'b0, "cleared irq");
    exp_msg.push_back({CFGIR_MSG_DEASSERT, 8'h00});
    exp_msg.push_back({CFGIR_MSG_ASSERT, 8'h00});
    wr(CFGIR_A_CTRL, 32'h0);
    wr(CFGIR_A_CTRL, 32'h1);
    drain();
    // Disable while asserted: the user end lets go, the endpoint stays silent
    cmd_wr <= 1'b1;
    cmd_wr_data <= 6'h20;
    cyc(1);
    cmd_wr <= 1'b0;
    cyc(8);
    chk(int_status === 1'b0 && lnk.intx_req_n === 1'b1, "muted release");
    exp_msg.push_back({CFGIR_MSG_ASSERT, 8'h00});
    cmd_wr <= 1'b1;
    cmd_wr_data <= 6'h00;
    cyc(1);
    cmd_wr <= 1'b0;
    drain();
    exp_msg.push_back({CFGIR_MSG_DEASSERT, 8'h00});
    wr(CFGIR_A_CTRL, 32'h0);
    drain();
    msi_en_in <= 1'b1;
    cyc(2);
    old = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      v = (i == 0) ? 8'hFF : (i[0] ? 8'h00 : rnd[7:0]);
      if ((v & ~old) != 8'h00) exp_msg.push_back({CFGIR_MSG_MSI, v & ~old});
      wr(CFGIR_A_MSI, {24'h0, v});
      old = v;
    end
    drain();
    wr(CFGIR_A_STAT, 32'h7);
    cyc(3);
    wr(CFGIR_A_CTRL, 32'h1);
    cyc(8);
    chk(int_status === 1'b0 && lnk.msi_on === 1'b1, "msi mode");
    rd(CFGIR_A_STAT, 32'h2);
    rd(CFGIR_A_CTRL, 32'h4);
    drain();
    complete_run();
  end
endmodule : cfg_outputs_and_intr_request_bench
